/* rtl/smbds_defs.vh */
`ifndef SMBDS_DEFS_VH
`define SMBDS_DEFS_VH

// Register offsets on the special-function register port
`define SMBDS_OFS_STATE_CODE  8'hc1
`define SMBDS_OFS_DATA_BYTE   8'hc2
`define SMBDS_OFS_OWN_ADDR    8'hc3

// Reset values
`define SMBDS_RST_STATE_CODE  8'hf8
`define SMBDS_RST_DATA_BYTE   8'h00
`define SMBDS_RST_OWN_ADDR    8'h00

// Field positions of own_slave_address
`define SMBDS_ADDR_MSB        7
`define SMBDS_ADDR_LSB        1
`define SMBDS_GCALL_BIT       0

// Bit counter marks
`define SMBDS_BIT_ACK         4'h8
`define SMBDS_BIT_DONE        4'h9

// Bus state codes
`define SMBDS_ST_BUS_ERROR    8'h00
`define SMBDS_ST_MT_ADDR_ACK  8'h18
`define SMBDS_ST_MT_ADDR_NAK  8'h20
`define SMBDS_ST_MT_DATA_ACK  8'h28
`define SMBDS_ST_MT_DATA_NAK  8'h30
`define SMBDS_ST_ARB_LOST     8'h38
`define SMBDS_ST_MR_ADDR_ACK  8'h40
`define SMBDS_ST_MR_ADDR_NAK  8'h48
`define SMBDS_ST_MR_DATA_ACK  8'h50
`define SMBDS_ST_MR_DATA_NAK  8'h58
`define SMBDS_ST_SR_OWN       8'h60
`define SMBDS_ST_SR_OWN_ARB   8'h68
`define SMBDS_ST_SR_GC        8'h70
`define SMBDS_ST_SR_GC_ARB    8'h78
`define SMBDS_ST_SR_DATA_ACK  8'h80
`define SMBDS_ST_SR_DATA_NAK  8'h88
`define SMBDS_ST_SR_GC_ACK    8'h90
`define SMBDS_ST_SR_GC_NAK    8'h98
`define SMBDS_ST_SR_STOP      8'ha0
`define SMBDS_ST_ST_OWN       8'ha8
`define SMBDS_ST_ST_OWN_ARB   8'hb0
`define SMBDS_ST_ST_DATA_ACK  8'hb8
`define SMBDS_ST_ST_DATA_NAK  8'hc0

`endif

/* rtl/smbds_sync.v */
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; the output follows only once stages two and three agree
module smbds_sync #(
	parameter RST_VAL = 1'b1
) (
	input  wire clk,
	input  wire srst,
	input  wire pin_in,
	output reg  level_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge clk) begin
		if (srst) begin
			s1_q    <= RST_VAL;
			s2_q    <= RST_VAL;
			s3_q    <= RST_VAL;
			level_q <= RST_VAL;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule // smbds_sync

`default_nettype wire

/* rtl/smbds_buf.v */
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer; in_ready low stalls the shifter, which then stretches SCL
module smbds_buf #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:1];
	reg             wptr_q;
	reg             rptr_q;
	reg [1:0]       cnt_q;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);

	always @* begin
		out_data = mem[rptr_q];
	end

	always @(posedge clk) begin
		if (push) begin
			mem[wptr_q] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wptr_q <= 1'b0;
			rptr_q <= 1'b0;
			cnt_q  <= 2'd0;
		end else begin
			if (push) begin
				wptr_q <= ~wptr_q;
			end
			if (pop) begin
				rptr_q <= ~rptr_q;
			end
			case ({push, pop})
			2'b10: cnt_q <= cnt_q + 2'd1;
			2'b01: cnt_q <= cnt_q - 2'd1;
			default: cnt_q <= cnt_q;
			endcase
		end
	end
endmodule // smbds_buf

`default_nettype wire

/* rtl/smbds_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "smbds_defs.vh"

module smbds_top #(
	parameter BUF_WIDTH = 8
) (
	input  wire                 clk,
	input  wire                 srst,
	input  wire [7:0]           sfr_addr,
	input  wire                 sfr_wr,
	input  wire                 sfr_rd,
	input  wire [7:0]           sfr_wdata,
	output reg  [7:0]           sfr_rdata,
	input  wire                 event_flag,
	input  wire                 bus_enable,
	input  wire                 master_mode,
	input  wire                 ack_enable,
	output reg                  state_event,
	input  wire                 scl_in,
	output wire                 scl_out,
	output reg                  scl_oe,
	input  wire                 sda_in,
	output wire                 sda_out,
	output reg                  sda_oe,
	output wire                 rx_valid,
	input  wire                 rx_ready,
	output wire [BUF_WIDTH-1:0] rx_data
);
	localparam PH_IDLE = 2'd0;
	localparam PH_ADDR = 2'd1;
	localparam PH_DATA = 2'd2;

	wire       scl_f;
	wire       sda_f;
	reg        scl_prev_q;
	reg        sda_prev_q;
	reg  [7:0] data_q;
	reg  [7:0] own_addr_q;
	reg  [7:0] code_q;
	reg  [3:0] bit_q;
	reg  [1:0] phase_q;
	reg        tx_q;
	reg        rw_q;
	reg        arb_q;
	reg        addressed_q;
	reg        gcall_q;
	reg        ack_seen_q;
	reg        push_q;
	reg        stretch_q;
	reg  [7:0] end_code;
	reg        end_event;
	wire       buf_ready;

	// Open-drain pins: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	smbds_sync #(
		.RST_VAL (1'b1)
	) u_scl_sync (
		.clk     (clk),
		.srst    (srst),
		.pin_in  (scl_in),
		.level_q (scl_f)
	);

	smbds_sync #(
		.RST_VAL (1'b1)
	) u_sda_sync (
		.clk     (clk),
		.srst    (srst),
		.pin_in  (sda_in),
		.level_q (sda_f)
	);

	smbds_buf #(
		.WIDTH (BUF_WIDTH)
	) u_rx_buf (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (push_q),
		.in_ready  (buf_ready),
		.in_data   (data_q[BUF_WIDTH-1:0]),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	wire scl_rise   = scl_f & ~scl_prev_q;
	wire scl_fall   = ~scl_f & scl_prev_q;
	wire start_cond = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	wire stop_cond  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
	// The first SCL rise of a byte may belong to a STOP or repeated START, so it is no error yet
	wire mid_byte   = (phase_q != PH_IDLE) && (bit_q > 4'h1);
	wire shift_ok   = bus_enable & ~event_flag & ~stretch_q;

	// Address matching is blind in master mode unless arbitration has been lost
	wire own_hit = ~master_mode & ~arb_q ? 1'b0 : 1'b0;
	wire slave_look = ~master_mode | arb_q;
	wire addr_hit = slave_look &
		(data_q[7:1] == own_addr_q[`SMBDS_ADDR_MSB:`SMBDS_ADDR_LSB]);
	wire gc_hit = slave_look & (data_q == 8'h00) &
		own_addr_q[`SMBDS_GCALL_BIT];

	// Whether this end pulls SDA low in the acknowledge slot
	reg ack_go;
	always @* begin
		ack_go = 1'b0;
		if (!tx_q) begin
			if (phase_q == PH_ADDR) begin
				ack_go = ack_enable & (addr_hit | gc_hit);
			end else if (phase_q == PH_DATA) begin
				ack_go = ack_enable;
			end
		end
	end

	// State reached at the end of a byte and its acknowledge
	always @* begin
		end_code  = code_q;
		end_event = 1'b1;
		if (phase_q == PH_ADDR) begin
			if (master_mode && !arb_q) begin
				if (data_q[0]) begin
					end_code = ack_seen_q ? `SMBDS_ST_MR_ADDR_ACK : `SMBDS_ST_MR_ADDR_NAK;
				end else begin
					end_code = ack_seen_q ? `SMBDS_ST_MT_ADDR_ACK : `SMBDS_ST_MT_ADDR_NAK;
				end
			end else if (addr_hit && ack_enable) begin
				if (data_q[0]) begin
					end_code = arb_q ? `SMBDS_ST_ST_OWN_ARB : `SMBDS_ST_ST_OWN;
				end else begin
					end_code = arb_q ? `SMBDS_ST_SR_OWN_ARB : `SMBDS_ST_SR_OWN;
				end
			end else if (gc_hit && ack_enable) begin
				end_code = arb_q ? `SMBDS_ST_SR_GC_ARB : `SMBDS_ST_SR_GC;
			end else if (arb_q) begin
				end_code = `SMBDS_ST_ARB_LOST;
			end else begin
				end_event = 1'b0;
			end
		end else if (arb_q) begin
			end_code = `SMBDS_ST_ARB_LOST;
		end else if (master_mode) begin
			if (tx_q) begin
				end_code = ack_seen_q ? `SMBDS_ST_MT_DATA_ACK : `SMBDS_ST_MT_DATA_NAK;
			end else begin
				end_code = ack_enable ? `SMBDS_ST_MR_DATA_ACK : `SMBDS_ST_MR_DATA_NAK;
			end
		end else if (tx_q) begin
			end_code = ack_seen_q ? `SMBDS_ST_ST_DATA_ACK : `SMBDS_ST_ST_DATA_NAK;
		end else if (gcall_q) begin
			end_code = ack_enable ? `SMBDS_ST_SR_GC_ACK : `SMBDS_ST_SR_GC_NAK;
		end else begin
			end_code = ack_enable ? `SMBDS_ST_SR_DATA_ACK : `SMBDS_ST_SR_DATA_NAK;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
		end
	end

	// Byte engine
	always @(posedge clk) begin
		if (srst) begin
			data_q      <= `SMBDS_RST_DATA_BYTE;
			code_q      <= `SMBDS_RST_STATE_CODE;
			bit_q       <= 4'h0;
			phase_q     <= PH_IDLE;
			tx_q        <= 1'b0;
			rw_q        <= 1'b0;
			arb_q       <= 1'b0;
			addressed_q <= 1'b0;
			gcall_q     <= 1'b0;
			ack_seen_q  <= 1'b0;
			push_q      <= 1'b0;
			state_event <= 1'b0;
		end else begin
			state_event <= 1'b0;
			if (push_q && buf_ready) begin
				push_q <= 1'b0;
			end
			if (sfr_wr && event_flag && sfr_addr == `SMBDS_OFS_DATA_BYTE) begin
				data_q <= sfr_wdata;
			end
			if (!bus_enable) begin
				phase_q     <= PH_IDLE;
				bit_q       <= 4'h0;
				addressed_q <= 1'b0;
			end else if ((start_cond || stop_cond) && mid_byte) begin
				code_q      <= `SMBDS_ST_BUS_ERROR;
				state_event <= 1'b1;
				phase_q     <= PH_IDLE;
				bit_q       <= 4'h0;
				addressed_q <= 1'b0;
				tx_q        <= 1'b0;
			end else if (start_cond || stop_cond) begin
				if (addressed_q && !master_mode) begin
					code_q      <= `SMBDS_ST_SR_STOP;
					state_event <= 1'b1;
				end
				phase_q     <= start_cond ? PH_ADDR : PH_IDLE;
				bit_q       <= 4'h0;
				addressed_q <= 1'b0;
				gcall_q     <= 1'b0;
				arb_q       <= 1'b0;
				tx_q        <= start_cond & master_mode;
			end else if (phase_q != PH_IDLE && shift_ok) begin
				if (scl_rise && bit_q < `SMBDS_BIT_ACK) begin
					// Bus level goes in whether sending or receiving
					data_q <= {data_q[6:0], sda_f};
					bit_q  <= bit_q + 4'h1;
					if (tx_q && !sda_oe && !sda_f && master_mode) begin
						tx_q  <= 1'b0;
						arb_q <= 1'b1;
					end
				end else if (scl_rise && bit_q == `SMBDS_BIT_ACK) begin
					ack_seen_q <= ~sda_f;
					bit_q      <= `SMBDS_BIT_DONE;
				end else if (scl_fall && bit_q == `SMBDS_BIT_DONE) begin
					bit_q       <= 4'h0;
					state_event <= end_event;
					if (end_event) begin
						code_q <= end_code;
					end
					if (!tx_q && phase_q == PH_DATA) begin
						push_q <= 1'b1;
					end
					if (phase_q == PH_ADDR) begin
						rw_q <= data_q[0];
						if (master_mode && !arb_q) begin
							phase_q <= ack_seen_q ? PH_DATA : PH_IDLE;
							tx_q    <= ~data_q[0];
						end else if ((addr_hit | gc_hit) && ack_enable) begin
							phase_q     <= PH_DATA;
							addressed_q <= 1'b1;
							gcall_q     <= gc_hit & ~addr_hit;
							tx_q        <= addr_hit & data_q[0];
						end else begin
							phase_q <= PH_IDLE;
							tx_q    <= 1'b0;
						end
					end else if (tx_q && !ack_seen_q) begin
						phase_q <= PH_IDLE;
						tx_q    <= 1'b0;
					end
				end
			end
		end
	end

	// Pin drive: SCL held low while software services an event or the buffer is full
	always @(posedge clk) begin
		if (srst) begin
			stretch_q <= 1'b0;
			scl_oe    <= 1'b0;
			sda_oe    <= 1'b0;
		end else begin
			stretch_q <= push_q & ~buf_ready;
			scl_oe    <= bus_enable & ~scl_f & (phase_q != PH_IDLE) &
				(event_flag | (push_q & ~buf_ready));
			if (!bus_enable || phase_q == PH_IDLE) begin
				sda_oe <= 1'b0;
			end else if (!scl_f) begin
				if (bit_q < `SMBDS_BIT_ACK) begin
					sda_oe <= tx_q & ~data_q[7];
				end else if (bit_q == `SMBDS_BIT_ACK) begin
					sda_oe <= ack_go;
				end else begin
					sda_oe <= 1'b0;
				end
			end
		end
	end

	// Register port; state code writes are dropped
	always @(posedge clk) begin
		if (srst) begin
			own_addr_q <= `SMBDS_RST_OWN_ADDR;
			sfr_rdata  <= 8'h00;
		end else begin
			if (sfr_wr && sfr_addr == `SMBDS_OFS_OWN_ADDR) begin
				own_addr_q <= sfr_wdata;
			end
			if (sfr_rd) begin
				case (sfr_addr)
				`SMBDS_OFS_STATE_CODE: sfr_rdata <= event_flag ?
					{code_q[7:3], 3'b000} : {code_q[7:3], bit_q[2:0]};
				// Reads while shifting may tear; software waits for the flag
				`SMBDS_OFS_DATA_BYTE:  sfr_rdata <= data_q;
				`SMBDS_OFS_OWN_ADDR:   sfr_rdata <= own_addr_q;
				default:               sfr_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Keeps otherwise unused values visible to lint; no logic depends on them
	wire unused_ok = own_hit & rw_q;
endmodule // smbds_top

`default_nettype wire

/* tb/smbds_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module smbds_chk #(
	parameter BUF_WIDTH = 8
) (
	input wire logic                 clk,
	input wire logic                 srst,
	input wire logic [7:0]           sfr_addr,
	input wire logic                 sfr_wr,
	input wire logic                 sfr_rd,
	input wire logic [7:0]           sfr_wdata,
	input wire logic [7:0]           sfr_rdata,
	input wire logic                 event_flag,
	input wire logic                 state_event,
	input wire logic                 scl_oe,
	input wire logic                 rx_valid,
	input wire logic                 rx_ready,
	input wire logic [BUF_WIDTH-1:0] rx_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	property p_rst;
		$fell(srst) |-> !state_event && !scl_oe && !rx_valid && sfr_rdata == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");

	property p_low0;
		sfr_rd && sfr_addr == 8'hc1 && event_flag |=> sfr_rdata[2:0] == 3'h0;
	endproperty
	a_low0: assert property (p_low0) else $error("state code low bits set");

	property p_unmap;
		sfr_rd && (sfr_addr < 8'hc1 || sfr_addr > 8'hc3) |=> sfr_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");

	sequence s_rd_data;
		sfr_rd && sfr_addr == 8'hc2 && event_flag && !sfr_wr;
	endsequence
	property p_hold;
		s_rd_data ##1 s_rd_data |=> sfr_rdata == $past(sfr_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("data byte moved while flag set");

	property p_wr_rd;
		event_flag && sfr_wr && sfr_addr == 8'hc2 ##1 sfr_rd && sfr_addr == 8'hc2
			|=> sfr_rdata == $past(sfr_wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("data byte write lost");

	property p_pulse;
		state_event |=> !state_event;
	endproperty
	a_pulse: assert property (p_pulse) else $error("state event longer than one cycle");

	property p_stretch;
		scl_oe && event_flag |=> scl_oe;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock released under flag");

	property p_noev;
		event_flag && $past(event_flag) |-> !state_event;
	endproperty
	a_noev: assert property (p_noev) else $error("new state while flag set");

	property p_rxhold;
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
	endproperty
	a_rxhold: assert property (p_rxhold) else $error("stalled byte lost");
endmodule // smbds_chk
`default_nettype wire

/* tb/smbds_mstr.sv */
`timescale 1ns/100ps
`default_nettype none
// Bus master; SCL low 250 ns and high 150 ns so the slave's late SDA update still settles
module smbds_mstr (
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_lo,
	output var  logic sda_lo
);
	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end
	// Waiting on the wire honours clock stretching by the slave
	task automatic clk_bit(input logic d, output logic q);
		#50 sda_lo = !d;
		#200 scl_lo = 1'b0;
		wait (scl);
		#140 q = sda;
		#10 scl_lo = 1'b1;
	endtask
	task automatic start();
		#50 sda_lo = 1'b0;
		#200 scl_lo = 1'b0;
		wait (scl);
		#150 sda_lo = 1'b1;
		#150 scl_lo = 1'b1;
	endtask
	task automatic stop();
		#50 sda_lo = 1'b1;
		#200 scl_lo = 1'b0;
		wait (scl);
		#150 sda_lo = 1'b0;
		#250;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic a9, output logic [7:0] rx,
			output logic q9);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], rx[i]);
		end
		clk_bit(a9, q9);
	endtask
endmodule // smbds_mstr
`default_nettype wire

/* tb/test_smbus_data_address_status.sv */
`timescale 1ns/100ps
`default_nettype none
`include "smbds_defs.vh"
module test_smbus_data_address_status;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic       event_flag = 1'b0;
	logic       ack_enable = 1'b1;
	logic       rx_ready = 1'b0;
	logic [7:0] sfr_rdata, rx_data, rx_b;
	logic       state_event, scl_out, scl_oe, sda_out, sda_oe, rx_valid;
	logic       m_scl_lo, m_sda_lo, scl_w, sda_w, q9;
	int         bad_count = 0;
	int         checked = 0;
	int         evt_n = 0;
	int         evt_seen = 0;

	assign scl_w = (scl_oe ? scl_out : 1'b1) & !m_scl_lo;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & !m_sda_lo;

	initial begin
		forever #25 clk = !clk;
	end

	smbds_top dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.event_flag(event_flag), .bus_enable(1'b1), .master_mode(1'b0),
		.ack_enable(ack_enable), .state_event(state_event), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
	smbds_mstr m (.scl(scl_w), .sda(sda_w), .scl_lo(m_scl_lo), .sda_lo(m_sda_lo));

	// Stands in for the control block: every new state raises the flag
	always @(negedge clk) begin
		if (state_event === 1'b1) begin
			event_flag <= 1'b1;
			evt_n <= evt_n + 1;
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		check(sfr_rdata, exp);
		@(negedge clk);
	endtask
	task automatic rd2(input logic [7:0] exp);
		sfr_addr = 8'hc2;
		sfr_rd = 1'b1;
		@(negedge clk);
		check(sfr_rdata, exp);
		@(negedge clk);
		sfr_rd = 1'b0;
		check(sfr_rdata, exp);
		@(negedge clk);
	endtask
	task automatic ev(input logic [7:0] code);
		int n;
		n = 0;
		while (evt_n == evt_seen && n < 400) begin
			@(negedge clk);
			n++;
		end
		evt_seen = evt_n;
		@(negedge clk);
		rd(8'hc1, code);
	endtask
	// Stray states after a STOP are absorbed here so they cannot stall the next frame
	task automatic idle();
		repeat (20) @(negedge clk);
		event_flag = 1'b0;
		evt_seen = evt_n;
	endtask
	task automatic give_verdict();
		$display("checked %0d, bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		bad_count++;
		give_verdict();
	end

	initial begin
		repeat (16) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		rd(8'hc1, 8'hf8);
		rd(8'hc2, 8'h00);
		rd(8'hc4, 8'h00);
		wr(8'hc3, 8'h54);
		rd(8'hc3, 8'h54);
		$display("register test done");
		m.start();
		m.xfer(8'h00, 1'b1, rx_b, q9);
		check({7'h00, q9}, 8'h01);
		m.stop();
		idle();
		wr(8'hc3, 8'h55);
		m.start();
		m.xfer(8'h00, 1'b1, rx_b, q9);
		check({7'h00, q9}, 8'h00);
		ev(`SMBDS_ST_SR_GC);
		event_flag = 1'b0;
		m.stop();
		idle();
		$display("general call test done");
		m.start();
		m.xfer(8'h54, 1'b1, rx_b, q9);
		ev(`SMBDS_ST_SR_OWN);
		rd(8'hc2, 8'h54);
		event_flag = 1'b0;
		m.xfer(8'ha5, 1'b1, rx_b, q9);
		ev(`SMBDS_ST_SR_DATA_ACK);
		rd2(8'ha5);
		event_flag = 1'b0;
		m.xfer(8'h3c, 1'b1, rx_b, q9);
		ev(`SMBDS_ST_SR_DATA_ACK);
		event_flag = 1'b0;
		m.xfer(8'h96, 1'b1, rx_b, q9);
		repeat (40) @(negedge clk);
		check({7'h00, scl_oe}, 8'h01);
		check(rx_data, 8'ha5);
		rx_ready = 1'b1;
		@(negedge clk);
		rx_ready = 1'b0;
		check(rx_data, 8'h3c);
		ev(`SMBDS_ST_SR_DATA_ACK);
		rd(8'hc2, 8'h96);
		rx_ready = 1'b1;
		repeat (4) @(negedge clk);
		check({7'h00, rx_valid}, 8'h00);
		event_flag = 1'b0;
		m.stop();
		ev(`SMBDS_ST_SR_STOP);
		idle();
		$display("slave receive test done");
		m.start();
		m.xfer(8'h55, 1'b1, rx_b, q9);
		ev(`SMBDS_ST_ST_OWN);
		wr(8'hc2, 8'hc3);
		rd(8'hc2, 8'hc3);
		event_flag = 1'b0;
		m.xfer(8'hff, 1'b1, rx_b, q9);
		check(rx_b, 8'hc3);
		ev(`SMBDS_ST_ST_DATA_NAK);
		event_flag = 1'b0;
		m.stop();
		idle();
		$display("slave transmit test done");
		m.start();
		m.clk_bit(1'b0, q9);
		m.clk_bit(1'b1, q9);
		m.stop();
		ev(`SMBDS_ST_BUS_ERROR);
		idle();
		$display("bus error test done");
		give_verdict();
	end
endmodule // test_smbus_data_address_status

bind smbds_top smbds_chk #(.BUF_WIDTH(BUF_WIDTH)) chk (.clk(clk), .srst(srst),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .event_flag(event_flag), .state_event(state_event),
	.scl_oe(scl_oe), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
`default_nettype wire
